// ==== dfcs_pkg.sv ====
package dfcs_pkg;

	// ------------------------------------------------------------------
	// Widths and timing
	// ------------------------------------------------------------------
	localparam int FREQ_W           = 16;
	localparam int HOLDT_W          = 10;
	localparam int CNT_W            = 24;
	localparam int CLK_FREQ_HZ      = 125_000_000;
	localparam int HOLD_UNIT_MS     = 100;
	localparam int HOLD_UNIT_CYCLES = CLK_FREQ_HZ / 1000 * HOLD_UNIT_MS;
	localparam int RAMP_TICK_US     = 1000;
	localparam int RAMP_TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * RAMP_TICK_US;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_UPPER1 = 8'h04;
	localparam logic [7:0] ADDR_LOWER1 = 8'h08;
	localparam logic [7:0] ADDR_UPPER2 = 8'h0C;
	localparam logic [7:0] ADDR_LOWER2 = 8'h10;
	localparam logic [7:0] ADDR_MAXF   = 8'h14;
	localparam logic [7:0] ADDR_JC1    = 8'h18;
	localparam logic [7:0] ADDR_JW1    = 8'h1C;
	localparam logic [7:0] ADDR_JC2    = 8'h20;
	localparam logic [7:0] ADDR_JW2    = 8'h24;
	localparam logic [7:0] ADDR_JC3    = 8'h28;
	localparam logic [7:0] ADDR_JW3    = 8'h2C;
	localparam logic [7:0] ADDR_HOLDF  = 8'h30;
	localparam logic [7:0] ADDR_HOLDT  = 8'h34;
	localparam logic [7:0] ADDR_RATE   = 8'h38;
	localparam logic [7:0] ADDR_STATUS = 8'h3C;
	localparam logic [7:0] ADDR_TARGET = 8'h40;

	// ------------------------------------------------------------------
	// Control fields and reset values
	// ------------------------------------------------------------------
	localparam int CTRL_W          = 7;
	localparam int CTRL_MSET_LSB   = 0;
	localparam int CTRL_SRC_BIT    = 2;
	localparam int CTRL_PDIR_BIT   = 3;
	localparam int CTRL_PRUN_BIT   = 4;
	localparam int CTRL_CURVE_LSB  = 5;
	localparam int STAT_REV_BIT    = 16;
	localparam int STAT_RUN_BIT    = 17;
	localparam int STAT_HOLD_BIT   = 18;
	localparam logic [1:0] MOTOR_SET_THIRD = 2'h2;
	localparam logic [1:0] MOTOR_SET_SECOND = 2'h1;
	localparam logic [CTRL_W-1:0] CTRL_RST  = 7'h00;
	localparam logic [FREQ_W-1:0] FREQ_RST  = 16'h0000;
	localparam logic [FREQ_W-1:0] RATE_RST  = 16'h0001;
	localparam logic [HOLDT_W-1:0] HOLDT_RST = 10'h000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RAMP,
		ST_HOLD
	} dfcs_state_t;

endpackage : dfcs_pkg

// ==== dfcs_band_if.sv ====
interface dfcs_band_if #(
	parameter int W = 16
);
	logic [W-1:0] freq_in;
	logic [W-1:0] center;
	logic [W-1:0] width;
	logic [W-1:0] freq_out;

	modport band (input freq_in, input center, input width, output freq_out);
	modport ctl  (output freq_in, output center, output width, input freq_out);
endinterface : dfcs_band_if

// ==== dfcs_band.sv ====
module dfcs_band
	import dfcs_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic     clk_i,   // System clock.
	input  wire logic     rst_b_i, // Asynchronous reset, active low.
	dfcs_band_if.band     bif      // One band of the avoidance chain.
);
	logic [W:0]   lo;
	logic [W:0]   hi;
	logic [W-1:0] out_nxt;

	// ------------------------------------------------------------------
	// Band edge computation
	// ------------------------------------------------------------------
	always_comb begin
		lo = (bif.center > bif.width) ?
			{1'b0, bif.center - bif.width} : '0;
		hi = {1'b0, bif.center} + {1'b0, bif.width};
		out_nxt = bif.freq_in;
		if (bif.center != '0) begin
			if ({1'b0, bif.freq_in} > lo && {1'b0, bif.freq_in} < hi) begin
				if (bif.freq_in < bif.center) begin
					out_nxt = lo[W-1:0];
				end else if (hi[W]) begin
					out_nxt = lo[W-1:0];
				end else begin
					out_nxt = hi[W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bif.freq_out <= '0;
		end else begin
			bif.freq_out <= out_nxt;
		end
	end

endmodule : dfcs_band

// ==== dfcs_top.sv ====
// Local design decisions: register access over APB and the address map.
module dfcs_top
	import dfcs_pkg::*;
#(
	parameter int HOLD_UNIT = HOLD_UNIT_CYCLES, // Cycles per 0.1 s.
	parameter int RAMP_TICK = RAMP_TICK_CYCLES  // Cycles per ramp step.
) (
	input  wire logic              MCLK_I,                // 125 MHz clock.
	input  wire logic              RST_B_I,               // Async reset, low.
	input  wire logic              PSEL_I,                // APB select.
	input  wire logic              PENABLE_I,             // APB enable.
	input  wire logic              PWRITE_I,              // APB write.
	input  wire logic [7:0]        PADDR_I,               // APB address.
	input  wire logic [31:0]       PWDATA_I,              // APB write data.
	output logic      [31:0]       PRDATA_O,              // APB read data.
	output logic                   PREADY_O,              // APB ready.
	output logic                   PSLVERR_O,             // APB error.
	input  wire logic [FREQ_W-1:0] FREQ_CMD_I,            // Command, 0.01 Hz.
	input  wire logic              CMD_FROM_BIPOLAR_I,    // Bipolar source.
	input  wire logic              BIPOLAR_ZERO_I,        // Bipolar at 0 V.
	input  wire logic              FORWARD_RUN_INPUT_I,   // Forward terminal.
	input  wire logic              REVERSE_RUN_INPUT_I,   // Reverse terminal.
	output logic      [FREQ_W-1:0] OUT_FREQ_O,            // Ramp output.
	output logic                   OUT_REVERSE_O,         // Reverse rotation.
	output logic                   RUNNING_O,             // Output active.
	output logic                   HOLD_ACTIVE_O          // Acceleration held.
);

	// ------------------------------------------------------------------
	// Register file state
	// ------------------------------------------------------------------
	logic [CTRL_W-1:0]  ctrl_r,  ctrl_nxt;
	logic [FREQ_W-1:0]  up1_r,   up1_nxt;
	logic [FREQ_W-1:0]  lo1_r,   lo1_nxt;
	logic [FREQ_W-1:0]  up2_r,   up2_nxt;
	logic [FREQ_W-1:0]  lo2_r,   lo2_nxt;
	logic [FREQ_W-1:0]  maxf_r,  maxf_nxt;
	logic [FREQ_W-1:0]  jc_r     [3];
	logic [FREQ_W-1:0]  jc_nxt   [3];
	logic [FREQ_W-1:0]  jw_r     [3];
	logic [FREQ_W-1:0]  jw_nxt   [3];
	logic [FREQ_W-1:0]  holdf_r, holdf_nxt;
	logic [HOLDT_W-1:0] holdt_r, holdt_nxt;
	logic [FREQ_W-1:0]  rate_r,  rate_nxt;
	logic [31:0]        prdata_r, prdata_nxt;
	logic               pready_r, pready_nxt;
	logic               pslverr_r, pslverr_nxt;
	logic               wr_en;
	logic               mapped;

	// ------------------------------------------------------------------
	// Command path state
	// ------------------------------------------------------------------
	logic [FREQ_W-1:0]  lim_r,   lim_nxt;
	logic [FREQ_W-1:0]  tgt_r,   tgt_nxt;
	logic               run_req_r, run_req_nxt;
	logic               dir_req_r, dir_req_nxt;
	logic [FREQ_W-1:0]  sel_up;
	logic [FREQ_W-1:0]  sel_lo;
	logic               third_set;
	logic               run_req;
	logic               dir_req;
	logic [FREQ_W-1:0]  cmd_src;

	// ------------------------------------------------------------------
	// Ramp state
	// ------------------------------------------------------------------
	dfcs_state_t        state_r, state_nxt;
	logic [FREQ_W-1:0]  freq_r,  freq_nxt;
	logic               rev_r,   rev_nxt;
	logic               armed_r, armed_nxt;
	logic               run_r,   run_nxt;
	logic               hold_r,  hold_nxt;
	logic [CNT_W-1:0]   tick_cnt_r, tick_cnt_nxt;
	logic [CNT_W-1:0]   unit_cnt_r, unit_cnt_nxt;
	logic [HOLDT_W-1:0] hold_cnt_r, hold_cnt_nxt;
	logic               tick;
	logic [FREQ_W-1:0]  goal;
	logic [FREQ_W:0]    step_up;

	dfcs_band_if #(.W(FREQ_W)) bands [3] ();

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// Ready is raised for the access cycle after every setup cycle, so
	// each transfer takes exactly two cycles and no wait state is added.
	always_comb begin
		ctrl_nxt  = ctrl_r;
		up1_nxt   = up1_r;
		lo1_nxt   = lo1_r;
		up2_nxt   = up2_r;
		lo2_nxt   = lo2_r;
		maxf_nxt  = maxf_r;
		jc_nxt    = jc_r;
		jw_nxt    = jw_r;
		holdf_nxt = holdf_r;
		holdt_nxt = holdt_r;
		rate_nxt  = rate_r;
		prdata_nxt = prdata_r;
		mapped    = 1'b1;
		wr_en     = PSEL_I & PENABLE_I & pready_r & PWRITE_I & ~pslverr_r;
		pready_nxt  = PSEL_I & ~PENABLE_I;
		pslverr_nxt = 1'b0;
		case (PADDR_I)
			ADDR_CTRL:   prdata_nxt = 32'(ctrl_r);
			ADDR_UPPER1: prdata_nxt = 32'(up1_r);
			ADDR_LOWER1: prdata_nxt = 32'(lo1_r);
			ADDR_UPPER2: prdata_nxt = 32'(up2_r);
			ADDR_LOWER2: prdata_nxt = 32'(lo2_r);
			ADDR_MAXF:   prdata_nxt = 32'(maxf_r);
			ADDR_JC1:    prdata_nxt = 32'(jc_r[0]);
			ADDR_JW1:    prdata_nxt = 32'(jw_r[0]);
			ADDR_JC2:    prdata_nxt = 32'(jc_r[1]);
			ADDR_JW2:    prdata_nxt = 32'(jw_r[1]);
			ADDR_JC3:    prdata_nxt = 32'(jc_r[2]);
			ADDR_JW3:    prdata_nxt = 32'(jw_r[2]);
			ADDR_HOLDF:  prdata_nxt = 32'(holdf_r);
			ADDR_HOLDT:  prdata_nxt = 32'(holdt_r);
			ADDR_RATE:   prdata_nxt = 32'(rate_r);
			ADDR_STATUS: prdata_nxt = {13'h0000, hold_r, run_r, rev_r, freq_r};
			ADDR_TARGET: prdata_nxt = 32'(tgt_r);
			default: begin
				prdata_nxt = 32'h0000_0000;
				mapped     = 1'b0;
			end
		endcase
		if (PSEL_I & ~PENABLE_I) begin
			pslverr_nxt = ~mapped;
		end else if (PSEL_I & PENABLE_I & ~pready_r) begin
			pslverr_nxt = pslverr_r;
		end
		if (wr_en) begin
			case (PADDR_I)
				ADDR_CTRL:   ctrl_nxt  = PWDATA_I[CTRL_W-1:0];
				ADDR_UPPER1: up1_nxt   = PWDATA_I[FREQ_W-1:0];
				ADDR_LOWER1: lo1_nxt   = PWDATA_I[FREQ_W-1:0];
				ADDR_UPPER2: up2_nxt   = PWDATA_I[FREQ_W-1:0];
				ADDR_LOWER2: lo2_nxt   = PWDATA_I[FREQ_W-1:0];
				ADDR_MAXF:   maxf_nxt  = PWDATA_I[FREQ_W-1:0];
				ADDR_JC1:    jc_nxt[0] = PWDATA_I[FREQ_W-1:0];
				ADDR_JW1:    jw_nxt[0] = PWDATA_I[FREQ_W-1:0];
				ADDR_JC2:    jc_nxt[1] = PWDATA_I[FREQ_W-1:0];
				ADDR_JW2:    jw_nxt[1] = PWDATA_I[FREQ_W-1:0];
				ADDR_JC3:    jc_nxt[2] = PWDATA_I[FREQ_W-1:0];
				ADDR_JW3:    jw_nxt[2] = PWDATA_I[FREQ_W-1:0];
				ADDR_HOLDF:  holdf_nxt = PWDATA_I[FREQ_W-1:0];
				ADDR_HOLDT:  holdt_nxt = PWDATA_I[HOLDT_W-1:0];
				ADDR_RATE:   rate_nxt  = PWDATA_I[FREQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_r    <= CTRL_RST;
			up1_r     <= FREQ_RST;
			lo1_r     <= FREQ_RST;
			up2_r     <= FREQ_RST;
			lo2_r     <= FREQ_RST;
			maxf_r    <= FREQ_RST;
			jc_r      <= '{default: FREQ_RST};
			jw_r      <= '{default: FREQ_RST};
			holdf_r   <= FREQ_RST;
			holdt_r   <= HOLDT_RST;
			rate_r    <= RATE_RST;
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			up1_r     <= up1_nxt;
			lo1_r     <= lo1_nxt;
			up2_r     <= up2_nxt;
			lo2_r     <= lo2_nxt;
			maxf_r    <= maxf_nxt;
			jc_r      <= jc_nxt;
			jw_r      <= jw_nxt;
			holdf_r   <= holdf_nxt;
			holdt_r   <= holdt_nxt;
			rate_r    <= rate_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Limiter and zero-volt handling
	// ------------------------------------------------------------------
	always_comb begin
		third_set = (ctrl_r[CTRL_MSET_LSB +: 2] == MOTOR_SET_THIRD);
		if (ctrl_r[CTRL_MSET_LSB +: 2] == MOTOR_SET_SECOND) begin
			sel_up = up2_r;
			sel_lo = lo2_r;
		end else begin
			sel_up = up1_r;
			sel_lo = lo1_r;
		end
		if (ctrl_r[CTRL_SRC_BIT]) begin
			run_req = ctrl_r[CTRL_PRUN_BIT];
			dir_req = ctrl_r[CTRL_PDIR_BIT];
		end else begin
			run_req = FORWARD_RUN_INPUT_I ^ REVERSE_RUN_INPUT_I;
			dir_req = REVERSE_RUN_INPUT_I;
		end
		cmd_src = FREQ_CMD_I;
		if (CMD_FROM_BIPOLAR_I && BIPOLAR_ZERO_I && !third_set &&
				sel_lo != '0) begin
			cmd_src = sel_lo;
		end
		lim_nxt = cmd_src;
		if (!third_set && !(sel_up == '0 && sel_lo == '0)) begin
			if (sel_up != '0 && lim_nxt > sel_up) begin
				lim_nxt = sel_up;
			end
			if (sel_lo != '0 && lim_nxt < sel_lo) begin
				lim_nxt = sel_lo;
			end
		end
		if (maxf_r != '0 && lim_nxt > maxf_r) begin
			lim_nxt = maxf_r;
		end
		run_req_nxt = run_req;
		dir_req_nxt = dir_req;
		tgt_nxt = run_req_r ? bands[2].freq_out : '0;
	end

	// ------------------------------------------------------------------
	// Jump band chain
	// ------------------------------------------------------------------
	// limit then jump
	for (genvar g = 0; g < 3; g++) begin : g_band
		assign bands[g].center = jc_r[g];
		assign bands[g].width  = jw_r[g];
		if (g == 0) begin : g_first
			assign bands[g].freq_in = lim_r;
		end else begin : g_next
			assign bands[g].freq_in = bands[g-1].freq_out;
		end
		dfcs_band #(.W(FREQ_W)) u_band (
			.clk_i   (MCLK_I),
			.rst_b_i (RST_B_I),
			.bif     (bands[g])
		);
	end

	// ------------------------------------------------------------------
	// Ramp with acceleration hold
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		freq_nxt     = freq_r;
		rev_nxt      = rev_r;
		armed_nxt    = armed_r;
		unit_cnt_nxt = unit_cnt_r;
		hold_cnt_nxt = hold_cnt_r;
		tick = (tick_cnt_r == CNT_W'(RAMP_TICK - 1));
		tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
		goal = (run_req_r && dir_req_r == rev_r) ? tgt_r : '0;
		step_up = {1'b0, freq_r} + {1'b0, rate_r};
		case (state_r)
			ST_IDLE: begin
				freq_nxt = '0;
				if (run_req_r) begin
					rev_nxt   = dir_req_r;
					armed_nxt = 1'b1;
					state_nxt = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (tick) begin
					if (freq_r < goal) begin
						freq_nxt = (step_up > {1'b0, goal}) ?
							goal : step_up[FREQ_W-1:0];
						if (armed_r && holdf_r != '0 && freq_r < holdf_r &&
								freq_nxt >= holdf_r) begin
							freq_nxt  = holdf_r;
							armed_nxt = 1'b0;
							if (holdt_r != '0) begin
								unit_cnt_nxt = '0;
								hold_cnt_nxt = '0;
								state_nxt    = ST_HOLD;
							end
						end
					end else if (freq_r > goal) begin
						freq_nxt = (freq_r - goal > rate_r) ?
							freq_r - rate_r : goal;
					end
					if (freq_nxt == '0 && goal == '0) begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_HOLD: begin
				if (unit_cnt_r == CNT_W'(HOLD_UNIT - 1)) begin
					unit_cnt_nxt = '0;
					hold_cnt_nxt = hold_cnt_r + 1'b1;
					if (hold_cnt_nxt >= holdt_r) begin
						state_nxt = ST_RAMP;
					end
				end else begin
					unit_cnt_nxt = unit_cnt_r + 1'b1;
				end
				// A stop or reversal ends the pause so deceleration is
				// never delayed by the start-up hold.
				if (goal < freq_r) begin
					state_nxt = ST_RAMP;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		run_nxt  = (state_nxt != ST_IDLE);
		hold_nxt = (state_nxt == ST_HOLD);
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lim_r      <= FREQ_RST;
			tgt_r      <= FREQ_RST;
			run_req_r  <= 1'b0;
			dir_req_r  <= 1'b0;
			state_r    <= ST_IDLE;
			freq_r     <= FREQ_RST;
			rev_r      <= 1'b0;
			armed_r    <= 1'b0;
			run_r      <= 1'b0;
			hold_r     <= 1'b0;
			tick_cnt_r <= '0;
			unit_cnt_r <= '0;
			hold_cnt_r <= HOLDT_RST;
		end else begin
			lim_r      <= lim_nxt;
			tgt_r      <= tgt_nxt;
			run_req_r  <= run_req_nxt;
			dir_req_r  <= dir_req_nxt;
			state_r    <= state_nxt;
			freq_r     <= freq_nxt;
			rev_r      <= rev_nxt;
			armed_r    <= armed_nxt;
			run_r      <= run_nxt;
			hold_r     <= hold_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			unit_cnt_r <= unit_cnt_nxt;
			hold_cnt_r <= hold_cnt_nxt;
		end
	end

	assign PRDATA_O      = prdata_r;
	assign PREADY_O      = pready_r;
	assign PSLVERR_O     = pslverr_r;
	assign OUT_FREQ_O    = freq_r;
	assign OUT_REVERSE_O = rev_r;
	assign RUNNING_O     = run_r;
	assign HOLD_ACTIVE_O = hold_r;

endmodule : dfcs_top

// ==== dfcs_top_checker.sv ====
module dfcs_top_checker
	import dfcs_pkg::*;
(
	input wire logic              MCLK_I,        // Clock.
	input wire logic              RST_B_I,       // Reset, low.
	input wire logic              PSEL_I,        // Select.
	input wire logic              PENABLE_I,     // Enable.
	input wire logic [7:0]        PADDR_I,       // Address.
	input wire logic              PREADY_O,      // Ready.
	input wire logic              PSLVERR_O,     // Error.
	input wire logic [FREQ_W-1:0] OUT_FREQ_O,    // Output.
	input wire logic              RUNNING_O,     // Running.
	input wire logic              HOLD_ACTIVE_O  // Hold.
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RST_B_I);

	logic setup;
	logic mapped;
	assign setup  = PSEL_I && !PENABLE_I;
	assign mapped = PADDR_I <= 8'h40 && PADDR_I[1:0] == 2'h0;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	a_ready_setup: assert property (setup |=> PREADY_O)
		else $error("ready missing after setup");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property ($rose(PREADY_O) |-> $past(setup))
		else $error("ready without setup");
	a_err_unmapped: assert property (setup && !mapped |=> PSLVERR_O)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (setup && mapped |=> !PSLVERR_O)
		else $error("error on mapped address");

	// ------------------------------------------------------------
	// Ramp and hold
	// ------------------------------------------------------------
	// hold keeps frequency
	a_hold_steady: assert property (
		HOLD_ACTIVE_O ##1 HOLD_ACTIVE_O |-> $stable(OUT_FREQ_O))
		else $error("frequency moved during hold");
	a_hold_run: assert property (HOLD_ACTIVE_O |-> RUNNING_O)
		else $error("hold while idle");
	a_tick_gap: assert property (
		$changed(OUT_FREQ_O) |=> $stable(OUT_FREQ_O)[*3])
		else $error("output stepped between ticks");
	a_idle_zero: assert property (
		!RUNNING_O |-> OUT_FREQ_O == '0)
		else $error("idle with nonzero output");

	c_hold: cover property ($rose(HOLD_ACTIVE_O));
	c_err: cover property (PSLVERR_O);
	c_run: cover property ($rose(RUNNING_O));
endmodule : dfcs_top_checker

bind dfcs_top dfcs_top_checker chk_u (
	.MCLK_I(MCLK_I),
	.RST_B_I(RST_B_I),
	.PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I),
	.PADDR_I(PADDR_I),
	.PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O),
	.OUT_FREQ_O(OUT_FREQ_O),
	.RUNNING_O(RUNNING_O),
	.HOLD_ACTIVE_O(HOLD_ACTIVE_O)
);

// ==== dfcs_far.sv ====
module dfcs_far
	import dfcs_pkg::*;
(
	input  wire logic [FREQ_W-1:0] level_i, // Analog level.
	input  wire logic              bip_i,   // Bipolar used.
	input  wire logic              fw_i,    // Forward wanted.
	input  wire logic              rv_i,    // Reverse wanted.
	output logic      [FREQ_W-1:0] cmd_o,   // Command.
	output logic                   bip_o,   // Bipolar select.
	output logic                   zero_o,  // Zero volts.
	output logic                   fw_o,    // Forward pin.
	output logic                   rv_o     // Reverse pin.
);
	timeunit 1ns;
	timeprecision 100ps;

	// Only the bipolar converter can report a zero-volt input.
	assign cmd_o  = level_i;
	assign bip_o  = bip_i;
	assign zero_o = bip_i && level_i == '0;
	assign fw_o   = fw_i;
	assign rv_o   = rv_i;
endmodule : dfcs_far

// ==== drive_frequency_command_shaper_test.sv ====
module drive_frequency_command_shaper_test
	import dfcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic              mclk   = 1'b0;
	logic              rst_b  = 1'b0;
	logic              psel   = 1'b0;
	logic              pen    = 1'b0;
	logic              pwr    = 1'b0;
	logic [7:0]        paddr  = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [FREQ_W-1:0] level  = 16'h0000;
	logic              bip    = 1'b0;
	logic              fw     = 1'b0;
	logic              rv     = 1'b0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [FREQ_W-1:0] cmd;
	logic              bip_s;
	logic              zero;
	logic              fw_s;
	logic              rv_s;
	logic [FREQ_W-1:0] freq;
	logic              rev;
	logic              run;
	logic              hold;
	logic [31:0]       q;
	logic              e;
	int                fail_count = 0;
	int                compares = 0;
	int                k;
	logic              seen;

	always #4 mclk = ~mclk;

	dfcs_far far_u (.level_i(level), .bip_i(bip), .fw_i(fw), .rv_i(rv),
		.cmd_o(cmd), .bip_o(bip_s), .zero_o(zero), .fw_o(fw_s),
		.rv_o(rv_s));

	dfcs_top #(.HOLD_UNIT(10), .RAMP_TICK(4)) dut_u (
		.MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .FREQ_CMD_I(cmd),
		.CMD_FROM_BIPOLAR_I(bip_s), .BIPOLAR_ZERO_I(zero),
		.FORWARD_RUN_INPUT_I(fw_s), .REVERSE_RUN_INPUT_I(rv_s),
		.OUT_FREQ_O(freq), .OUT_REVERSE_O(rev), .RUNNING_O(run),
		.HOLD_ACTIVE_O(hold));

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic hang(input string m);
		fail_count++;
		$display("BAD %0t timeout in %s", $time, m);
		tally_and_finish();
	endtask : hang

	task automatic chk(input logic [31:0] got, input logic [31:0] x,
		input string m);
		compares++;
		if (got !== x) begin
			fail_count++;
			$display("BAD %0t %s got %h want %h", $time, m, got, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		n = 0;
		// Ready, read data and error are taken at the edge that samples
		// ready high, and the request is released at that same edge.
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) hang("bus");
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x, "read");
	endtask : rc

	task automatic wait_idle();
		int n;
		n = 0;
		while (run !== 1'b0 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 5000) hang("stop");
	endtask : wait_idle

	task automatic tgt(input logic [1:0] s, input logic [15:0] c,
		input logic [15:0] x);
		wr(ADDR_CTRL, 32'h14 | 32'(s));
		level <= c;
		repeat (8) @(posedge mclk);
		rc(ADDR_TARGET, {16'h0, x});
	endtask : tgt

	task automatic zv(input logic [31:0] ctl, input logic f,
		input logic r, input logic x);
		int n;
		wr(ADDR_CTRL, ctl);
		fw <= f;
		rv <= r;
		repeat (20) @(posedge mclk);
		n = 0;
		while (!(run === 1'b1 && freq === 16'h03E8) && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 5000) hang("zero volt");
		chk({31'h0, rev}, {31'h0, x}, "direction");
	endtask : zv

	initial begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		rc(ADDR_CTRL, 32'h0);
		rc(ADDR_RATE, 32'h1);
		rc(ADDR_HOLDT, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped");
		wr(ADDR_STATUS, 32'hFFFFFFFF);
		rc(ADDR_STATUS, 32'h0);
		$display("registers done");
		wr(ADDR_UPPER1, 32'h1388);
		wr(ADDR_LOWER1, 32'h03E8);
		wr(ADDR_UPPER2, 32'h0BB8);
		wr(ADDR_LOWER2, 32'h07D0);
		wr(ADDR_RATE, 32'h0400);
		tgt(2'h0, 16'h01F4, 16'h03E8);
		tgt(2'h0, 16'h09C4, 16'h09C4);
		tgt(2'h0, 16'h2328, 16'h1388);
		tgt(2'h1, 16'h01F4, 16'h07D0);
		tgt(2'h1, 16'h09C4, 16'h09C4);
		tgt(2'h1, 16'h2328, 16'h0BB8);
		tgt(2'h2, 16'h01F4, 16'h01F4);
		tgt(2'h2, 16'h2328, 16'h2328);
		$display("limits done");
		bip   <= 1'b1;
		level <= 16'h0000;
		zv(32'h14, 1'b0, 1'b0, 1'b0);
		zv(32'h1C, 1'b0, 1'b0, 1'b1);
		zv(32'h00, 1'b1, 1'b0, 1'b0);
		zv(32'h00, 1'b0, 1'b1, 1'b1);
		@(posedge mclk);
		bip <= 1'b0;
		fw  <= 1'b0;
		rv  <= 1'b0;
		$display("zero volt done");
		wr(ADDR_UPPER1, 32'h0);
		wr(ADDR_LOWER1, 32'h0);
		tgt(2'h0, 16'h2328, 16'h2328);
		wr(ADDR_MAXF, 32'h1F40);
		tgt(2'h0, 16'h2328, 16'h1F40);
		wr(ADDR_JC1, 32'h03E8);
		wr(ADDR_JW1, 32'h0064);
		wr(ADDR_JC2, 32'h0BB8);
		wr(ADDR_JW2, 32'h03E8);
		wr(ADDR_JW3, 32'h01F4);
		tgt(2'h0, 16'h03B6, 16'h0384);
		tgt(2'h0, 16'h041A, 16'h044C);
		tgt(2'h0, 16'h044C, 16'h044C);
		tgt(2'h0, 16'h0DAC, 16'h0FA0);
		tgt(2'h0, 16'h09C4, 16'h07D0);
		tgt(2'h0, 16'h00C8, 16'h00C8);
		$display("bands done");
		wr(ADDR_CTRL, 32'h04);
		wait_idle();
		wr(ADDR_RATE, 32'h0005);
		level <= 16'h07D0;
		wr(ADDR_CTRL, 32'h14);
		seen = 1'b0;
		k = 0;
		while (freq !== 16'h07D0 && k < 5000) begin
			@(negedge mclk);
			if (freq > 16'h0384 && freq < 16'h044C) seen = 1'b1;
			k++;
		end
		if (k >= 5000) hang("crossing");
		chk({31'h0, seen}, 32'h1, "band crossed");
		$display("crossing done");
		wr(ADDR_RATE, 32'h0040);
		wr(ADDR_HOLDF, 32'h01F4);
		wr(ADDR_HOLDT, 32'h0002);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CTRL, 32'h04 | (32'(c) << 5));
			wait_idle();
			wr(ADDR_CTRL, 32'h14 | (32'(c) << 5));
			k = 0;
			while (hold !== 1'b1 && k < 5000) begin
				@(negedge mclk);
				k++;
			end
			if (k >= 5000) hang("hold");
			chk({16'h0, freq}, 32'h01F4, "hold freq");
			k = 0;
			while (hold === 1'b1 && k < 100) begin
				@(negedge mclk);
				k++;
			end
			chk({31'h0, k >= 20 && k <= 21}, 32'h1, "hold len");
		end
		$display("hold done");
		tally_and_finish();
	end
endmodule : drive_frequency_command_shaper_test
